// ---- tbc_pkg.sv ----
// Purpose: shared constants and types of the timer time base
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   offsets are byte addresses on the low 8 address bits
package tbc_pkg;

    // ==========================================================
    // widths
    localparam int          CNT_W = 32;
    localparam int          PSC_W = 16;
    localparam int          NSRC  = 7;

    // ==========================================================
    // register offsets
    localparam logic [7:0]  OFS_CTL0  = 8'h00;
    localparam logic [7:0]  OFS_SMCFG = 8'h08;
    localparam logic [7:0]  OFS_STAT  = 8'h10;
    localparam logic [7:0]  OFS_SWEV  = 8'h14;
    localparam logic [7:0]  OFS_CNT   = 8'h24;
    localparam logic [7:0]  OFS_PSC   = 8'h28;
    localparam logic [7:0]  OFS_CAR   = 8'h2c;

    // ==========================================================
    // field positions
    localparam int          CTL0_CEN   = 0;
    localparam int          CTL0_UPDATE_DISABLE = 1;
    localparam int          CTL0_DIR   = 4;
    localparam int          CTL0_CAM   = 5;
    localparam int          SMC_SMS    = 0;
    localparam int          SMC_TSS    = 4;
    localparam int          SMC_FLT    = 8;
    localparam int          SMC_CHPOL  = 12;
    localparam int          SMC_EM1    = 14;
    localparam int          STAT_UPF   = 0;
    localparam int          SWEV_UPG   = 0;

    // ==========================================================
    // reset values and masks
    localparam logic [31:0] RST_CAR = 32'hffff_ffff;
    localparam logic [15:0] RST_PSC = 16'h0000;
    localparam logic [31:0] MASK16  = 32'h0000_ffff;
    localparam logic [31:0] MASK32  = 32'hffff_ffff;

    // source bit order at the edge detector
    localparam int          SRC_CH0 = 4;
    localparam int          SRC_CH1 = 5;
    localparam int          SRC_ETI = 6;

    typedef enum logic [1:0] {SRC_KERNEL, SRC_ITI, SRC_CHAN, SRC_EXT} tbc_src_e;

    // ==========================================================
    // state carriers
    typedef struct packed {
        logic [NSRC-1:0] s1;
        logic [NSRC-1:0] s2;
        logic [NSRC-1:0] s3;
        logic [NSRC-1:0] lvl;
        logic            filt;
        logic [3:0]      fcnt;
        logic [NSRC-1:0] rise;
        logic [NSRC-1:0] fall;
    } tbc_sync_s;

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              counter_run_enable;
        logic              update_disable;
        logic              dir;
        logic [1:0]        center_align_mode;
        logic [2:0]        sms;
        logic [2:0]        tss;
        logic [3:0]        flt;
        logic              chpol;
        logic              em1;
        logic              upf;
        logic [PSC_W-1:0]  psc_buf;
        logic [PSC_W-1:0]  psc_act;
        logic [CNT_W-1:0]  car_buf;
        logic [CNT_W-1:0]  car_act;
        logic [CNT_W-1:0]  cnt;
        logic [PSC_W-1:0]  pcnt;
        logic              uev;
        logic              pclk_pulse;
    } tbc_state_s;

endpackage

// ---- tbc_edge_sync.sv ----
// Purpose: synchronise trigger and pin inputs, filter the external
//          trigger and report rising and falling edges
// Assumes: inputs are asynchronous to pclk
// Notes:   edge pulses are one pclk cycle long
`timescale 1ns/100ps
module tbc_edge_sync (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // raw inputs and filter length
    input  wire logic [tbc_pkg::NSRC-1:0] raw_in,
    input  wire logic [3:0]               filt_len,
    // edge pulses
    output logic      [tbc_pkg::NSRC-1:0] rise,
    output logic      [tbc_pkg::NSRC-1:0] fall
);

    tbc_pkg::tbc_sync_s st_ff;
    tbc_pkg::tbc_sync_s nxt_st;
    logic [tbc_pkg::NSRC-1:0] nxt_lvl;

    // ==========================================================
    // per-bit agreement of stages two and three
    genvar gi;
    generate
        for (gi = 0; gi < tbc_pkg::NSRC; gi++) begin : g_lvl
            // stage one feeds stage two only
            assign nxt_lvl[gi] = (st_ff.s2[gi] == st_ff.s3[gi]) ? st_ff.s3[gi]
                                                               : st_ff.lvl[gi];
        end
    endgenerate

    // ==========================================================
    // next state
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.s1  = raw_in;
        nxt_st.s2  = st_ff.s1;
        nxt_st.s3  = st_ff.s2;
        nxt_st.lvl = nxt_lvl;
        // eti must differ for filt_len + 1 cycles before the filtered level moves
        if (st_ff.lvl[tbc_pkg::SRC_ETI] == st_ff.filt) begin
            nxt_st.fcnt = 4'h0;
        end else if (st_ff.fcnt >= filt_len) begin
            nxt_st.filt = st_ff.lvl[tbc_pkg::SRC_ETI];
            nxt_st.fcnt = 4'h0;
        end else begin
            nxt_st.fcnt = st_ff.fcnt + 4'h1;
        end
        nxt_st.rise = 7'h00;
        nxt_st.fall = 7'h00;
        nxt_st.rise[tbc_pkg::SRC_ETI] = nxt_st.filt & ~st_ff.filt;
        nxt_st.fall[tbc_pkg::SRC_ETI] = ~nxt_st.filt & st_ff.filt;
        for (int i = 0; i < tbc_pkg::SRC_ETI; i++) begin
            nxt_st.rise[i] = nxt_lvl[i] & ~st_ff.lvl[i];
            nxt_st.fall[i] = ~nxt_lvl[i] & st_ff.lvl[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rise = st_ff.rise;
    assign fall = st_ff.fall;

endmodule

// ---- tbc_time_base.sv ----
// Purpose: timer time base - clock source select, prescaler, counter
// Assumes: apb slave, zero wait, byte addresses on paddr[7:0]
// Notes:   counter width fixed per instance by WIDE_CNT
// Operation
// - select 000 uses the kernel clock
// - run enable divides input by prescale value plus one
// - select 1,2,3,7 uses trigger source choice
// - select 4,5,6 keeps the kernel clock
// - select 7, source 4-6: channel pin edges
// - select 7, source 0-3: trigger rising edges
// - mode one enable clocks from external trigger
// - select 7, source 7: external trigger
// - filter external trigger, pulse per rise
// - division factor 1 to 65536
// - new prescale applies at update event
// - up mode wraps, update on overflow
// - up mode software update clears counter
// - update disable suppresses update events
// - update event loads reload and prescale shadows
// - down mode reloads, update on underflow
// - down mode software update loads reload
// - center mode up then down, edge events
// - center mode direction is read-only status
// - center mode software update clears counter
// - center mode field picks flag events
// - counter 16 or 32 bits per instance
`timescale 1ns/100ps
module tbc_time_base #(
    parameter bit WIDE_CNT = 1'b1
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // clock sources
    input  wire logic [3:0]  internal_trigger_in,
    input  wire logic        channel_pin0,
    input  wire logic        channel_pin1,
    input  wire logic        external_trigger_input,
    // events
    output logic             update_event,
    output logic             prescaled_clock
);

    tbc_pkg::tbc_state_s st_ff;
    tbc_pkg::tbc_state_s nxt_st;
    logic [tbc_pkg::NSRC-1:0] rise;
    logic [tbc_pkg::NSRC-1:0] fall;
    tbc_pkg::tbc_src_e        src;
    logic                     tick;
    logic                     cnt_tick;
    logic                     wr;
    logic                     upg_wr;
    logic                     ov;
    logic                     un;
    logic [31:0]              cmask;
    logic [31:0]              rdata;
    logic                     hit;

    // ==========================================================
    // edge detection of outside sources
    tbc_edge_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .raw_in   ({external_trigger_input, channel_pin1, channel_pin0,
                    internal_trigger_in}),
        .filt_len (st_ff.flt),
        .rise     (rise),
        .fall     (fall)
    );

    // 16-bit instances clear the upper half of written reload and counter values and of up counts; reset reload is all ones
    assign cmask  = WIDE_CNT ? tbc_pkg::MASK32 : tbc_pkg::MASK16;
    assign wr     = psel & penable & pwrite & st_ff.pready;
    assign upg_wr = wr & (paddr == tbc_pkg::OFS_SWEV) & pwdata[tbc_pkg::SWEV_UPG];

    // ==========================================================
    // clock source select
    always_comb begin
        src = tbc_pkg::SRC_KERNEL;
        if (st_ff.em1) begin
            src = tbc_pkg::SRC_EXT;
        end else if (st_ff.sms inside {3'h1, 3'h2, 3'h3, 3'h7}) begin
            case (st_ff.tss)
                3'h0, 3'h1, 3'h2, 3'h3: src = tbc_pkg::SRC_ITI;
                3'h4, 3'h5, 3'h6:       src = tbc_pkg::SRC_CHAN;
                default:                src = tbc_pkg::SRC_EXT;
            endcase
        end
        // with em1 clear, select 000 and 100..110 stay on the kernel clock
    end

    always_comb begin
        case (src)
            tbc_pkg::SRC_ITI:  tick = rise[st_ff.tss[1:0]];
            tbc_pkg::SRC_CHAN: begin
                case (st_ff.tss)
                    3'h4:    tick = rise[tbc_pkg::SRC_CH0] | fall[tbc_pkg::SRC_CH0];
                    3'h5:    tick = st_ff.chpol ? fall[tbc_pkg::SRC_CH0]
                                                : rise[tbc_pkg::SRC_CH0];
                    default: tick = st_ff.chpol ? fall[tbc_pkg::SRC_CH1]
                                                : rise[tbc_pkg::SRC_CH1];
                endcase
            end
            tbc_pkg::SRC_EXT:  tick = rise[tbc_pkg::SRC_ETI];
            default:           tick = 1'b1;
        endcase
    end

    // prescaler counts 0..psc_act, so factor is psc_act + 1
    assign cnt_tick = st_ff.counter_run_enable & tick & (st_ff.pcnt == st_ff.psc_act);

    // ==========================================================
    // counter step and events
    always_comb begin
        ov = 1'b0;
        un = 1'b0;
        if (cnt_tick) begin
            if (st_ff.center_align_mode == 2'b00) begin
                if (!st_ff.dir) begin
                    ov = (st_ff.cnt >= st_ff.car_act);
                end else begin
                    un = (st_ff.cnt == '0);
                end
            end else begin
                if (!st_ff.dir) begin
                    ov = (st_ff.cnt == st_ff.car_act - 32'h1);
                end else begin
                    un = (st_ff.cnt == 32'h1);
                end
            end
        end
    end

    // ==========================================================
    // apb read data and decode
    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            tbc_pkg::OFS_CTL0: begin
                rdata[tbc_pkg::CTL0_CEN]                 = st_ff.counter_run_enable;
                rdata[tbc_pkg::CTL0_UPDATE_DISABLE]               = st_ff.update_disable;
                rdata[tbc_pkg::CTL0_DIR]                 = st_ff.dir;
                rdata[tbc_pkg::CTL0_CAM +: 2]            = st_ff.center_align_mode;
            end
            tbc_pkg::OFS_SMCFG: begin
                rdata[tbc_pkg::SMC_SMS +: 3]             = st_ff.sms;
                rdata[tbc_pkg::SMC_TSS +: 3]             = st_ff.tss;
                rdata[tbc_pkg::SMC_FLT +: 4]             = st_ff.flt;
                rdata[tbc_pkg::SMC_CHPOL]                = st_ff.chpol;
                rdata[tbc_pkg::SMC_EM1]                  = st_ff.em1;
            end
            tbc_pkg::OFS_STAT: rdata[tbc_pkg::STAT_UPF] = st_ff.upf;
            tbc_pkg::OFS_SWEV: rdata = 32'h0000_0000;
            tbc_pkg::OFS_CNT:  rdata = st_ff.cnt;
            tbc_pkg::OFS_PSC:  rdata[tbc_pkg::PSC_W-1:0] = st_ff.psc_buf;
            tbc_pkg::OFS_CAR:  rdata = st_ff.car_buf;
            default:           hit = 1'b0;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        nxt_st            = st_ff;
        nxt_st.uev        = 1'b0;
        nxt_st.pclk_pulse = cnt_tick;
        // answer is prepared in setup so access completes at once
        nxt_st.pready     = psel & ~penable;
        nxt_st.pslverr    = psel & ~penable & ~hit;
        if (psel && !penable && !pwrite) begin
            nxt_st.prdata = rdata;
        end

        if (wr) begin
            case (paddr)
                tbc_pkg::OFS_CTL0: begin
                    nxt_st.counter_run_enable   = pwdata[tbc_pkg::CTL0_CEN];
                    nxt_st.update_disable = pwdata[tbc_pkg::CTL0_UPDATE_DISABLE];
                    nxt_st.center_align_mode   = pwdata[tbc_pkg::CTL0_CAM +: 2];
                    // hardware owns the direction in center mode
                    if (st_ff.center_align_mode == 2'b00) begin
                        nxt_st.dir = pwdata[tbc_pkg::CTL0_DIR];
                    end
                end
                tbc_pkg::OFS_SMCFG: begin
                    nxt_st.sms   = pwdata[tbc_pkg::SMC_SMS +: 3];
                    nxt_st.tss   = pwdata[tbc_pkg::SMC_TSS +: 3];
                    nxt_st.flt   = pwdata[tbc_pkg::SMC_FLT +: 4];
                    nxt_st.chpol = pwdata[tbc_pkg::SMC_CHPOL];
                    nxt_st.em1   = pwdata[tbc_pkg::SMC_EM1];
                end
                tbc_pkg::OFS_STAT: begin
                    if (!pwdata[tbc_pkg::STAT_UPF]) begin
                        nxt_st.upf = 1'b0;
                    end
                end
                tbc_pkg::OFS_PSC: nxt_st.psc_buf = pwdata[tbc_pkg::PSC_W-1:0];
                tbc_pkg::OFS_CAR: nxt_st.car_buf = pwdata & cmask;
                tbc_pkg::OFS_CNT: nxt_st.cnt     = pwdata & cmask;
                default: ;
            endcase
        end

        // prescaler, frozen while stopped
        if (st_ff.counter_run_enable && tick) begin
            nxt_st.pcnt = cnt_tick ? '0 : st_ff.pcnt + 16'h1;
        end

        // counter
        if (cnt_tick) begin
            if (st_ff.center_align_mode == 2'b00) begin
                if (!st_ff.dir) begin
                    nxt_st.cnt = ov ? '0 : (st_ff.cnt + 32'h1) & cmask;
                end else begin
                    nxt_st.cnt = un ? st_ff.car_act : st_ff.cnt - 32'h1;
                end
            end else if (!st_ff.dir) begin
                nxt_st.cnt = (st_ff.cnt + 32'h1) & cmask;
                if (ov) begin
                    nxt_st.dir = 1'b1;
                end
            end else begin
                nxt_st.cnt = st_ff.cnt - 32'h1;
                if (un) begin
                    nxt_st.dir = 1'b0;
                end
            end
        end

        // software update wins over counting
        if (upg_wr) begin
            nxt_st.pcnt = '0;
            if (st_ff.center_align_mode == 2'b00 && st_ff.dir) begin
                nxt_st.cnt = st_ff.car_act;
            end else begin
                nxt_st.cnt = '0;
            end
        end

        // update event and shadow load
        if ((ov || un || upg_wr) && !st_ff.update_disable) begin
            nxt_st.uev     = 1'b1;
            nxt_st.psc_act = nxt_st.psc_buf;
            nxt_st.car_act = nxt_st.car_buf;
            // set wins over a same-cycle clear
            if (upg_wr || st_ff.center_align_mode == 2'b00 || (st_ff.center_align_mode[0] && un) ||
                (st_ff.center_align_mode[1] && ov)) begin
                nxt_st.upf = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff         <= '0;
            st_ff.psc_buf <= tbc_pkg::RST_PSC;
            st_ff.psc_act <= tbc_pkg::RST_PSC;
            st_ff.car_buf <= tbc_pkg::RST_CAR;
            st_ff.car_act <= tbc_pkg::RST_CAR;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata          = st_ff.prdata;
    assign pready          = st_ff.pready;
    assign pslverr         = st_ff.pslverr;
    assign update_event    = st_ff.uev;
    assign prescaled_clock = st_ff.pclk_pulse;

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_kernel_div1;
        (st_ff.counter_run_enable && st_ff.sms == 3'h0 && !st_ff.em1 && st_ff.psc_act == 16'h0)
            |=> prescaled_clock;
    endproperty
    a_kernel_div1: assert property (p_kernel_div1) else $error("kernel tick lost");

    property p_div3;
        (cnt_tick && st_ff.psc_act == 16'h2 && src == tbc_pkg::SRC_KERNEL && st_ff.counter_run_enable
         && !upg_wr) ##1 (st_ff.counter_run_enable && !upg_wr && !(ov || un))[*2]
            |=> !prescaled_clock;
    endproperty
    a_div3: assert property (p_div3) else $error("divide by three broken");

    property p_psc_shadow;
        !nxt_st.uev |=> $stable(st_ff.psc_act);
    endproperty
    a_psc_shadow: assert property (p_psc_shadow) else $error("prescale moved early");

    property p_update_disable;
        st_ff.update_disable && !wr |=> !update_event;
    endproperty
    a_update_disable: assert property (p_update_disable) else $error("update not suppressed");

    sequence s_up_wrap;
        cnt_tick && st_ff.center_align_mode == 2'b00 && !st_ff.dir && st_ff.cnt >= st_ff.car_act
            && !wr && !st_ff.update_disable;
    endsequence
    property p_up_wrap;
        s_up_wrap |=> st_ff.cnt == '0 && update_event;
    endproperty
    a_up_wrap: assert property (p_up_wrap) else $error("up wrap wrong");

    sequence s_dn_under;
        cnt_tick && st_ff.center_align_mode == 2'b00 && st_ff.dir && st_ff.cnt == '0 && !wr;
    endsequence
    property p_dn_under;
        s_dn_under |=> st_ff.cnt == $past(st_ff.car_act);
    endproperty
    a_dn_under: assert property (p_dn_under) else $error("down reload wrong");

    property p_upg_clear;
        upg_wr && !(st_ff.center_align_mode == 2'b00 && st_ff.dir) |=> st_ff.cnt == '0;
    endproperty
    a_upg_clear: assert property (p_upg_clear) else $error("upg did not clear");

    property p_hold;
        !st_ff.counter_run_enable && !wr |=> $stable(st_ff.cnt);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved while stopped");

    property p_cam_flag;
        ov && st_ff.center_align_mode == 2'b01 && !st_ff.upf && !upg_wr |=> !st_ff.upf;
    endproperty
    a_cam_flag: assert property (p_cam_flag) else $error("flag set on overflow");

    property p_eti_only;
        src == tbc_pkg::SRC_EXT && !rise[tbc_pkg::SRC_ETI] |=> !prescaled_clock;
    endproperty
    a_eti_only: assert property (p_eti_only) else $error("eti tick without edge");

endmodule

// ---- tbc_src_model.sv ----
// Purpose: far-side sources: peer triggers, channel pins, external trigger
// Assumes: the bench selects one source at a time
// Notes:   idle lines rest low; square wave of 8 pclk periods
`timescale 1ns/100ps
module tbc_src_model (
    // clock and control
    input  wire logic       pclk,
    input  wire logic [2:0] sel,
    input  wire logic       run,
    // sources toward the time base
    output logic      [3:0] internal_trigger_in,
    output logic            channel_pin0,
    output logic            channel_pin1,
    output logic            external_trigger_input
);
    // ==========================================================
    // wave
    // 4 high and 4 low, wider than the 2-cycle minimum of the synchronisers
    logic [2:0] ph_ff = 3'h0;
    logic       lvl;
    always @(posedge pclk) begin
        ph_ff <= ph_ff + 3'h1;
    end
    assign lvl = run & ph_ff[2];
    assign internal_trigger_in    = {4{lvl & (sel < 3'h4)}} & (4'h1 << sel[1:0]);
    assign channel_pin0           = lvl & (sel == 3'h4);
    assign channel_pin1           = lvl & (sel == 3'h5);
    assign external_trigger_input = lvl & (sel == 3'h6);
endmodule

// ---- tb_tbc_time_base.sv ----
// Purpose: self-checking bench of the timer time base
// Assumes: 16-bit counter instance, apb answers without wait states
// Notes:   an integer model replays the counted steps
`timescale 1ns/100ps
module tb_tbc_time_base;
    // ==========================================================
    // signals
    localparam logic [7:0] CTL = tbc_pkg::OFS_CTL0;
    localparam logic [7:0] SWV = tbc_pkg::OFS_SWEV;
    localparam logic [7:0] CNT = tbc_pkg::OFS_CNT;
    localparam logic [7:0] RELOAD_VALUE = tbc_pkg::OFS_CAR;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, update_event, prescaled_clock;
    logic [3:0]  internal_trigger_in;
    logic        channel_pin0, channel_pin1, external_trigger_input;
    logic [2:0]  sel     = 3'h0;
    logic        run     = 1'b0;
    int          failures, tests_run, npc, nue, ev;

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        npc <= npc + int'(prescaled_clock === 1'b1);
        nue <= nue + int'(update_event === 1'b1);
    end

    tbc_time_base #(.WIDE_CNT(1'b0)) tbc_time_base_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .internal_trigger_in, .channel_pin0, .channel_pin1,
        .external_trigger_input, .update_event, .prescaled_clock
    );
    tbc_src_model tbc_src_model_inst (
        .pclk, .sel, .run, .internal_trigger_in, .channel_pin0, .channel_pin1,
        .external_trigger_input
    );

    // ==========================================================
    // checks and bus
    task automatic summarize;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // synchroniser lag blurs the window edges by a cycle or two
    task automatic near(input int g, input int e);
        chk(32'(g > e - 3 && g < e + 3), 32'h1);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // ==========================================================
    // counting modes against the integer model
    task automatic run_cnt(input logic [31:0] ctl);
        int reload_value, c, d, counter_run_enable, ov, un, uo, uu, k, m;
        reload_value = 3 + int'($urandom % 6);
        c = 1 + int'($urandom % (reload_value - 1));
        counter_run_enable = int'(ctl[6:5] != 2'h0);
        wr(CTL, ctl);
        wr(CTL, ctl);
        wr(RELOAD_VALUE, 32'(reload_value));
        wr(SWV, 32'h1);
        wr(CNT, 32'(c));
        wr(tbc_pkg::OFS_STAT, 32'h0);
        apb(1'b0, CTL, 32'h0);
        d = int'(rd[4]);
        k = npc;
        ev = nue;
        wr(CTL, ctl | 32'h1);
        repeat (20 + $urandom % 40) @(posedge pclk);
        wr(CTL, ctl);
        repeat (6) @(posedge pclk);
        uo = 0;
        uu = 0;
        for (int i = 0; i < npc - k; i++) begin
            ov = int'(d == 0 && (counter_run_enable == 1 ? c == reload_value - 1 : c == reload_value));
            un = int'(d == 1 && c == counter_run_enable);
            c = (counter_run_enable == 0 && ov == 1) ? 0 : (counter_run_enable == 0 && un == 1) ? reload_value : d ? c - 1 : c + 1;
            if (counter_run_enable == 1 && ov + un > 0) d = 1 - d;
            uo += ov;
            uu += un;
        end
        apb(1'b0, CNT, 32'h0);
        chk(rd, 32'(c));
        chk(32'(nue - ev), 32'(uo + uu));
        apb(1'b0, CTL, 32'h0);
        chk(32'(rd[4]), 32'(d));
        apb(1'b0, tbc_pkg::OFS_STAT, 32'h0);
        m = counter_run_enable == 1 ? int'(ctl[6:5]) : 3;
        chk(32'(rd[0]), 32'((m[1] && uo > 0) || (m[0] && uu > 0)));
        ev = nue;
        wr(SWV, 32'h1);
        repeat (3) @(posedge pclk);
        apb(1'b0, CNT, 32'h0);
        chk(rd, (counter_run_enable == 0 && d == 1) ? 32'(reload_value) : 32'h0);
        chk(32'(nue - ev), 32'h1);
    endtask

    // ==========================================================
    // clock sources: steps counted over a fixed enabled window
    task automatic rate(input logic [31:0] sm, input logic [2:0] s, input int x);
        int k;
        wr(tbc_pkg::OFS_SMCFG, sm);
        sel <= s;
        run <= 1'b1;
        k = npc;
        wr(CTL, 32'h1);
        repeat (160) @(posedge pclk);
        wr(CTL, 32'h0);
        run <= 1'b0;
        repeat (6) @(posedge pclk);
        near(npc - k, x);
        k = npc;
        repeat (20) @(posedge pclk);
        chk(32'(npc - k), 32'h0);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        summarize();
    end

    initial begin
        void'($urandom(66));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, RELOAD_VALUE, 32'h0);
        chk(rd, tbc_pkg::RST_CAR);
        apb(1'b0, tbc_pkg::OFS_PSC, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        wr(RELOAD_VALUE, 32'h0001_2345);
        apb(1'b0, RELOAD_VALUE, 32'h0);
        chk(rd, 32'h0000_2345);
        for (int cm = 1; cm < 4; cm++) run_cnt(32'(cm) << 5);
        run_cnt(32'h0);
        run_cnt(32'h10);
        wr(CTL, 32'h2);
        ev = nue;
        wr(SWV, 32'h1);
        repeat (3) @(posedge pclk);
        chk(32'(nue - ev), 32'h0);
        // update disable must be off again, or the shadow loads below never happen
        wr(CTL, 32'h0);
        wr(RELOAD_VALUE, 32'h0000_ffff);
        wr(SWV, 32'h1);
        wr(tbc_pkg::OFS_PSC, 32'h2);
        rate(32'h0, 3'h0, 163);
        wr(SWV, 32'h1);
        rate(32'h0, 3'h0, 54);
        wr(tbc_pkg::OFS_PSC, 32'h0);
        wr(SWV, 32'h1);
        for (int s = 4; s < 7; s++) rate(32'(s), 3'h0, 163);
        rate(32'h4000, 3'h6, 20);
        rate(32'h11, 3'h1, 20);
        for (int t = 0; t < 8; t++)
            rate((32'(t) << 4) | 32'h7, t < 4 ? 3'(t) : t < 6 ? 3'h4 : 3'(t - 1),
                 t == 4 ? 40 : 20);
        rate(32'h1057, 3'h4, 20);
        // 4-cycle pulses never outlast a filter of 16 cycles
        rate(32'h4f00, 3'h6, 0);
        summarize();
    end
endmodule
